//--- core/bac_params.svh
// Constants of the bus area configuration block
`ifndef BAC_PARAMS_SVH
`define BAC_PARAMS_SVH

// ----------------------------------------
// Register bus map
// ----------------------------------------
`define BAC_ADR_W 8
`define BAC_REG_OFS 8'h00
`define BAC_RESET_VAL 16'h0000
`define BAC_WMASK 16'h37FF
`define BAC_RSV_MASK 16'hC000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BAC_STBY_FLOAT_BIT 13
`define BAC_STRB_FLOAT_BIT 12
`define BAC_ORDER_BIT 11
`define BAC_A0_BURST_LSB 9
`define BAC_A5_BURST_LSB 7
`define BAC_A6_BURST_LSB 5
`define BAC_MTYPE_LSB 2
`define BAC_A5_CARD_BIT 1
`define BAC_A6_CARD_BIT 0

// ----------------------------------------
// Field codes and counts
// ----------------------------------------
`define BAC_BURST_ORD 2'h0
`define BAC_BURST_4 2'h1
`define BAC_BURST_8 2'h2
`define BAC_BEATS_0 5'h00
`define BAC_BEATS_4 5'h04
`define BAC_BEATS_8 5'h08
`define BAC_BEATS_16 5'h10
`define BAC_MT_NORMAL 3'h0
`define BAC_MT_A3_SDRAM 3'h2
`define BAC_MT_BOTH_SDRAM 3'h3
`define BAC_MT_A3_DRAM 3'h4
`define BAC_MT_BOTH_DRAM 3'h5
`define BAC_STRAP_SETTLE 3'h4

`endif

//--- core/bac_pkg.sv
// Types shared by the bus area configuration block
`include "bac_params.svh"
package bac_pkg;
  // Memory strobes that float or go high in standby
  typedef struct packed {
    logic bus_start;
    logic chip_sel;
    logic rd_wr;
    logic byte_en;
    logic rd;
    logic card_enable_2a;
    logic card_enable_2b;
    logic dma_ack_out;
  } strobe_t;

  // External memory pin values
  typedef struct packed {
    logic [25:0] addr;
    strobe_t strb;
    logic ras;
    logic cas;
  } mem_pins_t;

  // Output enables of the pin groups
  typedef struct packed {
    logic addr;
    logic strb;
    logic rascas;
  } pins_oe_t;

  // Strap capture states
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b01,
    ST_HELD = 2'b10
  } strap_st_t;
endpackage

//--- core/pin_sync3.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync3 (
  input wire logic clk_sys_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic pin_i, // Asynchronous pin
  output logic level_o // Filtered level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  assign level_o = level_q;
endmodule // pin_sync3

//--- core/standby_pin_ctl.sv
// Standby and bus release pin drive control
`timescale 1ns/10ps
module standby_pin_ctl
  import bac_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic standby_i, // Standby mode
  input wire logic bus_release_i, // Bus handed to another master
  input wire logic standby_pin_float_sel_i, // 1: drive in standby
  input wire logic strobe_float_sel_i, // 1: keep row/column strobes driven
  input wire mem_pins_t norm_pins_i, // Values from the bus controller
  output mem_pins_t pins_o, // Pin values
  output pins_oe_t pins_oe_o // Pin output enables
);
  mem_pins_t pins_d;
  mem_pins_t pins_q;
  pins_oe_t oe_d;
  pins_oe_t oe_q;
  logic rascas_idle;

  // Standby parks address low and strobes high, or floats them
  assign rascas_idle = standby_i | bus_release_i;
  assign pins_d.addr = standby_i ? '0 : norm_pins_i.addr;
  assign pins_d.strb = standby_i ? '1 : norm_pins_i.strb;
  assign pins_d.ras = norm_pins_i.ras;
  assign pins_d.cas = norm_pins_i.cas;
  assign oe_d.addr = ~standby_i | standby_pin_float_sel_i;
  assign oe_d.strb = ~standby_i | standby_pin_float_sel_i;
  assign oe_d.rascas = ~rascas_idle | strobe_float_sel_i;

  // Registered so the pads see glitch-free levels
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pins_q <= '0;
      oe_q <= '0;
    end else begin
      pins_q <= pins_d;
      oe_q <= oe_d;
    end
  end

  assign pins_o = pins_q;
  assign pins_oe_o = oe_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  property p_stby_drive;
    standby_i && standby_pin_float_sel_i |=> pins_oe_o.addr && pins_oe_o.strb && pins_o.addr == 26'h0 &&
      pins_o.strb == 8'hFF;
  endproperty
  a_stby_drive: assert property (p_stby_drive) else $error("standby drive levels wrong");

  property p_stby_float;
    standby_i && !standby_pin_float_sel_i |=> !pins_oe_o.addr && !pins_oe_o.strb;
  endproperty
  a_stby_float: assert property (p_stby_float) else $error("standby pins not floating");

  property p_rascas;
    (standby_i || bus_release_i) |=> pins_oe_o.rascas == $past(strobe_float_sel_i);
  endproperty
  a_rascas: assert property (p_rascas) else $error("row/column strobe float wrong");
endmodule // standby_pin_ctl

//--- core/bus_area_config.sv
// Bus area configuration register with Wishbone slave
`timescale 1ns/10ps
`include "bac_params.svh"

module bus_area_config
  import bac_pkg::*;
(
  input wire logic clk_sys_i, // System clock, 200 MHz
  input wire logic arst_n_i, // Power-on reset, async, active low
  input wire logic manual_rst_i, // Manual reset, leaves register alone
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [`BAC_ADR_W-1:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic byte_order_strap_i, // Byte order strap pin
  input wire logic standby_i, // Standby mode
  input wire logic bus_release_i, // Bus released to another master
  input wire mem_pins_t norm_pins_i, // Pin values from bus controller
  output mem_pins_t pins_o, // External memory pin values
  output pins_oe_t pins_oe_o, // External memory pin enables
  output logic [2:0][4:0] area_burst_beats_o, // Beats for areas 0,5,6; 0 = ordinary
  output logic area5_card_space_o, // Area 5 uses card interface
  output logic area6_card_space_o, // Area 6 uses card interface
  output logic area5_io_card_en_o, // Area 5 I/O card cycles allowed
  output logic area6_io_card_en_o, // Area 6 I/O card cycles allowed
  output logic area2_dram_o, // Area 2 is DRAM
  output logic area3_dram_o, // Area 3 is DRAM
  output logic area2_sdram_o, // Area 2 is SDRAM
  output logic area3_sdram_o, // Area 3 is SDRAM
  output logic mem_type_rsvd_o, // Reserved memory type code set
  output logic little_endian_o, // Byte order for all areas
  output logic strap_valid_o // Byte order flag has been latched
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [15:0] ctl_q;
  logic [15:0] ctl_d;
  logic [15:0] lane_mask;
  logic [15:0] wdat16;
  logic [15:0] rd_val;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic ack_q;
  logic ack_d;
  logic req;
  logic reg_hit;
  logic wr_hit;
  logic strap_lvl;
  logic strap_q;
  logic strap_d;
  strap_st_t st_q;
  strap_st_t st_d;
  logic [2:0] settle_q;
  logic [2:0] settle_d;
  logic [2:0] mtype;
  logic [5:0] burst_fields;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Unmapped words still ack, read as zero, and drop writes
  assign req = wb_cyc_i & wb_stb_i;
  assign reg_hit = (wb_adr_i[`BAC_ADR_W-1:2] == `BAC_REG_OFS >> 2);
  assign wr_hit = req & wb_we_i & ack_q & reg_hit;
  assign wdat16 = wb_dat_i[15:0];
  assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & `BAC_WMASK;
  assign ctl_d = (ctl_q & ~lane_mask) | (wdat16 & lane_mask);
  assign ack_d = req & ~ack_q;

  // Read view: reserved bits zero, flag from the latch
  assign rd_val = {2'h0, ctl_q[13:12], strap_q, ctl_q[10:0]};
  assign dat_d = (req & ~wb_we_i & reg_hit) ? {16'h0000, rd_val} : 32'h0000_0000;

  // One-cycle ack; write lands on the edge the master sees it
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  // Only power-on reset clears it; manual reset and standby are not inputs here
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_q <= `BAC_RESET_VAL;
    end else if (wr_hit) begin
      ctl_q <= ctl_d;
    end
  end

  // ----------------------------------------
  // Byte order strap capture
  // ----------------------------------------
  pin_sync3 u_strap_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .pin_i(byte_order_strap_i),
    .level_o(strap_lvl)
  );

  // Wait for the synchroniser to fill, then hold until next power-on
  always_comb begin
    st_d = st_q;
    settle_d = settle_q;
    strap_d = strap_q;
    case (st_q)
      ST_SETTLE: begin
        if (settle_q == `BAC_STRAP_SETTLE) begin
          strap_d = strap_lvl;
          st_d = ST_HELD;
        end else begin
          settle_d = settle_q + 3'h1;
        end
      end
      ST_HELD: begin
        strap_d = strap_q;
      end
      default: begin
        st_d = ST_SETTLE;
        settle_d = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= ST_SETTLE;
      settle_q <= 3'h0;
      strap_q <= 1'b0;
    end else begin
      st_q <= st_d;
      settle_q <= settle_d;
      strap_q <= strap_d;
    end
  end

  // ----------------------------------------
  // Decoded configuration
  // ----------------------------------------
  assign burst_fields = {ctl_q[`BAC_A6_BURST_LSB+:2], ctl_q[`BAC_A5_BURST_LSB+:2], ctl_q[`BAC_A0_BURST_LSB+:2]};

  // Burst beats per area; index 0 = area 0, 1 = area 5, 2 = area 6
  for (genvar g = 0; g < 3; g++) begin : g_burst
    logic [1:0] fld;
    assign fld = burst_fields[2*g+:2];
    assign area_burst_beats_o[g] = (fld == `BAC_BURST_ORD) ? `BAC_BEATS_0 :
                                   (fld == `BAC_BURST_4) ? `BAC_BEATS_4 :
                                   (fld == `BAC_BURST_8) ? `BAC_BEATS_8 : `BAC_BEATS_16;
  end

  // Area 2/3 memory type; reserved codes leave both areas normal
  assign mtype = ctl_q[`BAC_MTYPE_LSB+:3];
  assign area2_dram_o = (mtype == `BAC_MT_BOTH_DRAM);
  assign area3_dram_o = (mtype == `BAC_MT_BOTH_DRAM) | (mtype == `BAC_MT_A3_DRAM);
  assign area2_sdram_o = (mtype == `BAC_MT_BOTH_SDRAM);
  assign area3_sdram_o = (mtype == `BAC_MT_BOTH_SDRAM) | (mtype == `BAC_MT_A3_SDRAM);
  assign mem_type_rsvd_o = ~(area3_dram_o | area3_sdram_o | (mtype == `BAC_MT_NORMAL));

  // Card space; area 5 never runs I/O card cycles
  assign area5_card_space_o = ctl_q[`BAC_A5_CARD_BIT];
  assign area6_card_space_o = ctl_q[`BAC_A6_CARD_BIT];
  assign area5_io_card_en_o = 1'b0;
  assign area6_io_card_en_o = ctl_q[`BAC_A6_CARD_BIT];

  assign little_endian_o = strap_q;
  assign strap_valid_o = (st_q == ST_HELD);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  standby_pin_ctl u_pins (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .standby_i(standby_i),
    .bus_release_i(bus_release_i),
    .standby_pin_float_sel_i(ctl_q[`BAC_STBY_FLOAT_BIT]),
    .strobe_float_sel_i(ctl_q[`BAC_STRB_FLOAT_BIT]),
    .norm_pins_i(norm_pins_i),
    .pins_o(pins_o),
    .pins_oe_o(pins_oe_o)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_full_wr;
    wr_hit && wb_sel_i[1:0] == 2'h3;
  endsequence

  sequence s_ack_done;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_ack_pulse;
    wb_ack_o |-> s_ack_done;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_ack_latency;
    $rose(req) |=> wb_ack_o;
  endproperty
  a_ack_latency: assert property (p_ack_latency) else $error("ack not one cycle after request");

  property p_wr_update;
    s_full_wr |=> ctl_q == ($past(wdat16) & `BAC_WMASK);
  endproperty
  a_wr_update: assert property (p_wr_update) else $error("register write not stored");

  property p_manual_keep;
    manual_rst_i && !wr_hit |=> $stable(ctl_q);
  endproperty
  a_manual_keep: assert property (p_manual_keep) else $error("manual reset altered register");

  property p_rsv_zero;
    wb_ack_o |-> wb_dat_o[15:14] == 2'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");

  property p_strap_hold;
    strap_valid_o |=> $stable(strap_q) && strap_valid_o;
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("byte order flag changed");

  property p_strap_read;
    wb_ack_o && strap_valid_o && $past(reg_hit && !wb_we_i) |-> wb_dat_o[11] == little_endian_o;
  endproperty
  a_strap_read: assert property (p_strap_read) else $error("byte order read mismatch");

  property p_burst16;
    (s_full_wr and wdat16[`BAC_A0_BURST_LSB+:2] == 2'h3) |=> area_burst_beats_o[0] == 5'h10;
  endproperty
  a_burst16: assert property (p_burst16) else $error("area 0 burst length wrong");

  property p_burst16_a5;
    (s_full_wr and wdat16[`BAC_A5_BURST_LSB+:2] == 2'h3) |=> area_burst_beats_o[1] == 5'h10;
  endproperty
  a_burst16_a5: assert property (p_burst16_a5) else $error("area 5 burst length wrong");

  property p_burst4_a6;
    (s_full_wr and wdat16[`BAC_A6_BURST_LSB+:2] == 2'h1) |=> area_burst_beats_o[2] == 5'h04;
  endproperty
  a_burst4_a6: assert property (p_burst4_a6) else $error("area 6 burst length wrong");

  property p_rsv_stored;
    wr_hit |=> ctl_q[15:14] == 2'h0;
  endproperty
  a_rsv_stored: assert property (p_rsv_stored) else $error("reserved bits took a write");

  property p_flag_wr_ignored;
    wr_hit && wb_sel_i[1] && strap_valid_o |=> $stable(little_endian_o) && ctl_q[`BAC_ORDER_BIT] == 1'b0;
  endproperty
  a_flag_wr_ignored: assert property (p_flag_wr_ignored) else $error("byte order flag took a write");

  property p_mtype_rsvd;
    mtype == 3'h1 |-> mem_type_rsvd_o && !area2_dram_o && !area3_dram_o && !area2_sdram_o && !area3_sdram_o;
  endproperty
  a_mtype_rsvd: assert property (p_mtype_rsvd) else $error("reserved memory type decode wrong");

  property p_both_dram;
    mtype == `BAC_MT_BOTH_DRAM |-> area2_dram_o && area3_dram_o && !area3_sdram_o && !mem_type_rsvd_o;
  endproperty
  a_both_dram: assert property (p_both_dram) else $error("memory type decode wrong");

  property p_card5;
    wr_hit && wb_sel_i[0] |=> area5_card_space_o == $past(wb_dat_i[1]);
  endproperty
  a_card5: assert property (p_card5) else $error("area 5 card space not set");

  property p_card6;
    wr_hit && wb_sel_i[0] |=> area6_card_space_o == $past(wb_dat_i[0]);
  endproperty
  a_card6: assert property (p_card6) else $error("area 6 card space not set");

  property p_card6_io;
    area6_io_card_en_o == area6_card_space_o && !area5_io_card_en_o;
  endproperty
  a_card6_io: assert property (p_card6_io) else $error("card interface support wrong");
endmodule // bus_area_config

//--- sim/mem_partner.sv
// Far-side model: external memory pins as seen by memories and cards
`timescale 1ns/10ps
module mem_partner
  import bac_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire mem_pins_t pins_i, // Values driven by the block
  input wire pins_oe_t pins_oe_i, // Enables, high = driven
  output mem_pins_t wire_o // Level seen on the board
);
  mem_pins_t last_q;

  // ----------------------------------------
  // Floating lines
  // ----------------------------------------
  // No pull resistors here, so a released line shows the inverse of its
  // last driven value; a stale copy would hide a missing float
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_q <= '0;
    end else begin
      if (pins_oe_i.addr) begin
        last_q.addr <= pins_i.addr;
      end
      if (pins_oe_i.strb) begin
        last_q.strb <= pins_i.strb;
      end
      if (pins_oe_i.rascas) begin
        last_q.ras <= pins_i.ras;
        last_q.cas <= pins_i.cas;
      end
    end
  end

  // Resolved board levels
  assign wire_o.addr = pins_oe_i.addr ? pins_i.addr : ~last_q.addr;
  assign wire_o.strb = pins_oe_i.strb ? pins_i.strb : ~last_q.strb;
  assign wire_o.ras = pins_oe_i.rascas ? pins_i.ras : ~last_q.ras;
  assign wire_o.cas = pins_oe_i.rascas ? pins_i.cas : ~last_q.cas;
endmodule // mem_partner

//--- sim/bus_area_config_tb.sv
// Self-checking testbench of the bus area configuration register
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module bus_area_config_tb;
  import bac_pkg::*;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic manual_rst = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic strap = 1'b1;
  logic standby = 1'b0;
  logic bus_rel = 1'b0;
  mem_pins_t norm = '0;
  mem_pins_t pins;
  mem_pins_t wires;
  pins_oe_t oe;
  logic [2:0][4:0] beats;
  logic a5c, a6c, a5io, a6io, a2d, a3d, a2s, a3s, mtr, le, sv;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  // ----------------------------------------
  // Clock, timeout, instances
  // ----------------------------------------
  always #2.5 clk_sys_i = ~clk_sys_i;

  // Whole run is about 220 cycles; the ceiling leaves wide margin
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      report_and_stop();
    end
  end

  bus_area_config dut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .manual_rst_i(manual_rst),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .byte_order_strap_i(strap), .standby_i(standby), .bus_release_i(bus_rel),
    .norm_pins_i(norm), .pins_o(pins), .pins_oe_o(oe), .area_burst_beats_o(beats),
    .area5_card_space_o(a5c), .area6_card_space_o(a6c), .area5_io_card_en_o(a5io),
    .area6_io_card_en_o(a6io), .area2_dram_o(a2d), .area3_dram_o(a3d), .area2_sdram_o(a2s),
    .area3_sdram_o(a3s), .mem_type_rsvd_o(mtr), .little_endian_o(le), .strap_valid_o(sv)
  );

  mem_partner board (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .pins_i(pins), .pins_oe_i(oe), .wire_o(wires)
  );

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                         input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_wdat <= wd;
    // No wait limit of its own; the bench timeout ends a hung cycle
    do begin
      @(posedge clk_sys_i);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [15:0] d);
    logic [31:0] r;
    wb_xfer(1'b1, adr, sel, {16'hFFFF, d}, r);
    tick(1);
  endtask

  task automatic chk_rd(input logic [7:0] adr, input logic [15:0] exp);
    logic [31:0] r;
    wb_xfer(1'b0, adr, 4'hF, 32'h0000_0000, r);
    `CHK(r, {16'h0000, exp})
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [4:0] beats_of(input logic [1:0] c);
    case (c)
      2'h0: return 5'h00;
      2'h1: return 5'h04;
      2'h2: return 5'h08;
      default: return 5'h10;
    endcase
  endfunction

  // Expected {area2 dram, area3 dram, area2 sdram, area3 sdram, reserved}
  logic [4:0] mt_exp [8] = '{5'h00, 5'h01, 5'h02, 5'h06, 5'h08, 5'h18, 5'h01, 5'h01};

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [15:0] v;
    repeat (6) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    tick(8);
    // Configure before any access beyond area 0
    chk_rd(8'h00, 16'h0800);
    `CHK({le, sv}, 2'b11)
    wr(8'h00, 4'h3, 16'hFFFF);
    chk_rd(8'h00, 16'h3FFF);
    wr(8'h00, 4'h3, 16'h0000);
    chk_rd(8'h00, 16'h0800);
    wr(8'h00, 4'h2, 16'hFFFF);
    wr(8'h00, 4'h1, 16'h0000);
    chk_rd(8'h00, 16'h3F00);
    wr(8'h04, 4'h3, 16'h0000);
    chk_rd(8'h04, 16'h0000);
    chk_rd(8'h00, 16'h3F00);
    // Burst lengths chosen for an 8-bit bus, legal for every code
    for (int i = 0; i < 4; i++) begin
      v = {5'h00, i[1:0], i[1:0], i[1:0], 5'h00};
      wr(8'h00, 4'h3, v);
      `CHK(beats[0], beats_of(i[1:0]))
      `CHK(beats[1], beats_of(i[1:0]))
      `CHK(beats[2], beats_of(i[1:0]))
    end
    // Area 2 width taken as 16-bit when both areas are DRAM
    for (int i = 0; i < 8; i++) begin
      v = {11'h000, i[2:0], 2'h0};
      wr(8'h00, 4'h3, v);
      `CHK({a2d, a3d, a2s, a3s, mtr}, mt_exp[i])
      chk_rd(8'h00, v | 16'h0800);
    end
    // Card areas taken as 8 or 16-bit wide
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 4'h3, {14'h0000, i[1:0]});
      `CHK({a5c, a6c}, i[1:0])
      `CHK({a5io, a6io}, {1'b0, i[0]})
    end
    // Standby and bus release drive per float selects
    @(posedge clk_sys_i);
    norm <= mem_pins_t'(36'h9A5C35A3D);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 4'h3, {2'b00, i[1], i[0], 12'h000});
      @(posedge clk_sys_i);
      standby <= 1'b1;
      tick(2);
      `CHK(oe, pins_oe_t'({i[1], i[1], i[0]}))
      `CHK(pins, mem_pins_t'({26'h0000000, 8'hFF, norm.ras, norm.cas}))
      if (i[1]) `CHK({wires.addr, wires.strb}, {26'h0000000, 8'hFF})
      else `CHK(wires.addr, ~norm.addr)
      if (i[0]) `CHK({wires.ras, wires.cas}, {norm.ras, norm.cas})
      @(posedge clk_sys_i);
      standby <= 1'b0;
      bus_rel <= 1'b1;
      tick(2);
      `CHK(oe, pins_oe_t'({2'b11, i[0]}))
      `CHK(pins, norm)
      @(posedge clk_sys_i);
      bus_rel <= 1'b0;
      tick(2);
      `CHK({oe, wires}, {3'b111, norm})
    end
    // Manual reset leaves the register alone
    wr(8'h00, 4'h3, 16'h2AAA);
    @(posedge clk_sys_i);
    manual_rst <= 1'b1;
    tick(3);
    @(posedge clk_sys_i);
    manual_rst <= 1'b0;
    chk_rd(8'h00, 16'h2AAA);
    // Second power-on reset with the strap low
    strap <= 1'b0;
    arst_n_i <= 1'b0;
    tick(6);
    `CHK({sv, wb_ack}, 2'b00)
    @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    tick(8);
    chk_rd(8'h00, 16'h0000);
    `CHK({le, sv}, 2'b01)
    report_and_stop();
  end
endmodule // bus_area_config_tb
